// ===== logic/tsdc_setup_check.sv
`timescale 1ns/100ps
`include "tsdc_map.svh"
// Notes on behaviour
// - The device keeps recomputing the checksum and flags a status error on any mismatch.
// - The checksum low byte sits at location 249 and the high byte at location 250.
// - A key held above the positive threshold for the whole positive delay is recalibrated.
// - The positive recalibration delay is fixed at 1000 ms for all keys.
// - Indexed parameters 0 to 15 are translated to real values by an internal table.
// - The negative recalibration code steps 0.5 s per count and zero means infinite.
// - The time_a time code steps 0.1 s per count and zero is illegal.
// - The detection hold code steps 0.1 s per count and zero disables hold.
// - Both calibration offsets are used raw without translation.
// - The three idle-time codes are raw counts where zero means 256.
module tsdc_setup_check #(
  parameter int KEYS = 24,
  parameter longint PRD_CYCLES = `TSDC_PRD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire tsdc_pkg::tsdc_wr_t setup_wr,
  input wire logic [7:0] setup_raddr,
  output logic [7:0] setup_rdata,
  input wire logic [3:0] thr_index,
  output logic [5:0] thr_counts,
  input wire logic [KEYS-1:0] key_above_positive_threshold,
  output logic [KEYS-1:0] key_pos_recal,
  output logic crc_error,
  output logic time_a_illegal,
  output logic [15:0] computed_crc,
  output tsdc_pkg::tsdc_params_t params
);
  localparam int PRD_W = 40;
  logic [7:0] mem [`TSDC_SETUP_DEPTH];
  logic [7:0] scan_idx;
  logic [15:0] crc_acc;
  logic [15:0] next_crc;
  tsdc_pkg::tsdc_crc_state_t state;
  logic [PRD_W-1:0] prd_cnt [KEYS];
  logic [15:0] setups_checksum;
  logic [38:0] neg_recal_cycles;
  logic neg_recal_infinite;
  logic [37:0] time_a_cycles;
  logic [37:0] detection_hold_cycles;
  logic detection_hold_enable;
  logic [7:0] cal_offset_one;
  logic [7:0] cal_offset_two;
  logic [8:0] idle_zero;
  logic [8:0] idle_one;
  logic [8:0] idle_two;

  // ==========================================
  // Translation helpers.
  function automatic logic [5:0] thr_lookup(input logic [3:0] idx);
    logic [5:0] v;
    v = 6'h04 + {1'b0, idx, 1'b0};
    return (idx > 4'h7) ? 6'h12 : v;
  endfunction
  function automatic logic [8:0] idle_count(input logic [7:0] code);
    return (code == 8'h00) ? 9'h100 : {1'b0, code};
  endfunction

  // ==========================================
  // Setup storage written by the host.
  always_ff @(posedge core_clk) begin
    if (setup_wr.we && setup_wr.addr < 8'(`TSDC_SETUP_DEPTH)) begin
      mem[setup_wr.addr] <= setup_wr.wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      setup_rdata <= 8'h00;
    end else begin
      setup_rdata <= (setup_raddr < 8'(`TSDC_SETUP_DEPTH)) ? mem[setup_raddr] : 8'h00;
    end
  end

  // ==========================================
  // Host-supplied checksum, low byte first in the block.
  assign setups_checksum = {mem[`TSDC_CRC_HI_ADDR], mem[`TSDC_CRC_LO_ADDR]};

  // ==========================================
  // Continuous checksum over locations 0..248.
  tsdc_crc_step u_step (
    .crc_in(crc_acc),
    .data(mem[scan_idx]),
    .crc_out(next_crc)
  );
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= tsdc_pkg::TSDC_IDLE;
      scan_idx <= 8'h00;
      crc_acc <= `TSDC_CRC_INIT;
      crc_error <= 1'b0;
      computed_crc <= 16'h0000;
    end else begin
      case (state)
        tsdc_pkg::TSDC_IDLE: begin
          scan_idx <= 8'h00;
          crc_acc <= `TSDC_CRC_INIT;
          state <= tsdc_pkg::TSDC_RUN;
        end
        tsdc_pkg::TSDC_RUN: begin
          crc_acc <= next_crc;
          scan_idx <= scan_idx + 8'h01;
          if (scan_idx == `TSDC_CRC_LO_ADDR - 8'h01) begin
            state <= tsdc_pkg::TSDC_CHECK;
          end
        end
        tsdc_pkg::TSDC_CHECK: begin
          computed_crc <= crc_acc;
          crc_error <= crc_acc != setups_checksum;
          state <= tsdc_pkg::TSDC_IDLE;
        end
        default: begin
          state <= tsdc_pkg::TSDC_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Fixed positive recalibration timers per key.
  for (genvar k = 0; k < KEYS; k++) begin : g_key
    always_ff @(posedge core_clk) begin
      if (!rstn || !key_above_positive_threshold[k] || key_pos_recal[k]) begin
        prd_cnt[k] <= '0;
      end else begin
        prd_cnt[k] <= prd_cnt[k] + 40'h1;
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        key_pos_recal[k] <= 1'b0;
      end else begin
        key_pos_recal[k] <= key_above_positive_threshold[k] && !key_pos_recal[k]
                            && prd_cnt[k] == PRD_W'(PRD_CYCLES - 1);
      end
    end
  end

  // ==========================================
  // Threshold index translation.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      thr_counts <= 6'h04;
    end else begin
      thr_counts <= thr_lookup(thr_index);
    end
  end

  // ==========================================
  // Negative recalibration delay; a zero code never times out.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      neg_recal_cycles <= '0;
      neg_recal_infinite <= 1'b0;
    end else begin
      neg_recal_cycles <= 39'(mem[`TSDC_NEG_RECAL_ADDR]) * 39'(`TSDC_NRD_STEP_CYCLES);
      neg_recal_infinite <= mem[`TSDC_NEG_RECAL_ADDR] == 8'h00;
    end
  end

  // ==========================================
  // Time_a time; a zero code is flagged because it is not allowed.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      time_a_cycles <= '0;
      time_a_illegal <= 1'b0;
    end else begin
      time_a_cycles <= 38'(mem[`TSDC_TIME_A_ADDR]) * 38'(`TSDC_TENTH_STEP_CYCLES);
      time_a_illegal <= mem[`TSDC_TIME_A_ADDR] == 8'h00;
    end
  end

  // ==========================================
  // Detection hold time; a zero code turns the hold off.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      detection_hold_cycles <= '0;
      detection_hold_enable <= 1'b0;
    end else begin
      detection_hold_cycles <= 38'(mem[`TSDC_DHT_ADDR]) * 38'(`TSDC_TENTH_STEP_CYCLES);
      detection_hold_enable <= mem[`TSDC_DHT_ADDR] != 8'h00;
    end
  end

  // ==========================================
  // Calibration offsets pass through untranslated.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cal_offset_one <= 8'h00;
      cal_offset_two <= 8'h00;
    end else begin
      cal_offset_one <= mem[`TSDC_CFO_ONE_ADDR];
      cal_offset_two <= mem[`TSDC_CFO_TWO_ADDR];
    end
  end

  // ==========================================
  // Burst idle times, where a stored zero stands for the longest idle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      idle_zero <= 9'h000;
      idle_one <= 9'h000;
      idle_two <= 9'h000;
    end else begin
      idle_zero <= idle_count(mem[`TSDC_IDLE0_ADDR]);
      idle_one <= idle_count(mem[`TSDC_IDLE1_ADDR]);
      idle_two <= idle_count(mem[`TSDC_IDLE2_ADDR]);
    end
  end

  // ==========================================
  // Decoded values gathered for the sensing side.
  assign params = '{
    neg_recal_cycles: neg_recal_cycles,
    neg_recal_infinite: neg_recal_infinite,
    time_a_cycles: time_a_cycles,
    detection_hold_cycles: detection_hold_cycles,
    detection_hold_enable: detection_hold_enable,
    calibration_offset_one: cal_offset_one,
    calibration_offset_two: cal_offset_two,
    idle_time_zero: idle_zero,
    idle_time_one: idle_one,
    idle_time_two: idle_two
  };
endmodule

// ===== common/tsdc_map.svh
`ifndef TSDC_MAP_SVH
`define TSDC_MAP_SVH
// Setups block geometry.
`define TSDC_SETUP_DEPTH 251
`define TSDC_CRC_LO_ADDR 8'hf9
`define TSDC_CRC_HI_ADDR 8'hfa
`define TSDC_CRC_INIT 16'h0000
`define TSDC_CRC_POLY 16'h1021
// Parameter locations inside the setups block (chosen layout).
`define TSDC_NEG_RECAL_ADDR 8'hf0
`define TSDC_TIME_A_ADDR 8'hf1
`define TSDC_DHT_ADDR 8'hf2
`define TSDC_CFO_ONE_ADDR 8'hf3
`define TSDC_CFO_TWO_ADDR 8'hf4
`define TSDC_IDLE0_ADDR 8'hf5
`define TSDC_IDLE1_ADDR 8'hf6
`define TSDC_IDLE2_ADDR 8'hf7
`define TSDC_THR_ADDR 8'h00
// Timing in the units printed and derived cycle counts at 125 MHz.
`define TSDC_CLK_MHZ 125
`define TSDC_PRD_MS 1000
`define TSDC_PRD_CYCLES (`TSDC_PRD_MS * 1000 * `TSDC_CLK_MHZ)
`define TSDC_NRD_STEP_MS 500
`define TSDC_TENTH_STEP_MS 100
`define TSDC_NRD_STEP_CYCLES (`TSDC_NRD_STEP_MS * 1000 * `TSDC_CLK_MHZ)
`define TSDC_TENTH_STEP_CYCLES (`TSDC_TENTH_STEP_MS * 1000 * `TSDC_CLK_MHZ)
`endif

// ===== common/tsdc_pkg.sv
package tsdc_pkg;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsdc_wr_t;
  typedef struct packed {
    logic [38:0] neg_recal_cycles;
    logic neg_recal_infinite;
    logic [37:0] time_a_cycles;
    logic [37:0] detection_hold_cycles;
    logic detection_hold_enable;
    logic [7:0] calibration_offset_one;
    logic [7:0] calibration_offset_two;
    logic [8:0] idle_time_zero;
    logic [8:0] idle_time_one;
    logic [8:0] idle_time_two;
  } tsdc_params_t;
  typedef enum logic [1:0] {
    TSDC_IDLE,
    TSDC_RUN,
    TSDC_CHECK
  } tsdc_crc_state_t;
endpackage

// ===== logic/tsdc_crc_step.sv
`timescale 1ns/100ps
`include "tsdc_map.svh"
// ==========================================
// One byte of checksum update, MSB first.
module tsdc_crc_step (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  output logic [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ `TSDC_CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end
endmodule

// ===== tb/tsdc_sca_assertions.sv
`timescale 1ns/100ps
// ==========
// Port checks.
module tsdc_sca #(
  parameter int KEYS = 24
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire tsdc_pkg::tsdc_wr_t setup_wr,
  input wire logic [7:0] setup_raddr,
  input wire logic [7:0] setup_rdata,
  input wire logic [3:0] thr_index,
  input wire logic [5:0] thr_counts,
  input wire logic [KEYS-1:0] key_above_positive_threshold,
  input wire logic [KEYS-1:0] key_pos_recal,
  input wire logic crc_error,
  input wire logic time_a_illegal,
  input wire logic [15:0] computed_crc,
  input wire tsdc_pkg::tsdc_params_t params
);
  wire logic [8:0] wa = {setup_wr.we, setup_wr.addr};
  wire logic [7:0] wd = setup_wr.wdata;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  AST_RD0: assert property (setup_raddr > 8'hfa |=> setup_rdata == 8'h00) else $error("rdata");
  AST_THH: assert property (thr_index > 4'h7 |=> thr_counts == 6'h12) else $error("thr hi");
  AST_THL: assert property (thr_index < 4'h8 |=> thr_counts == 6'h04 + {1'b0, $past(thr_index), 1'b0}) else $error("thr");
  AST_NRI: assert property (wa == 9'h1f0 |-> ##3 params.neg_recal_infinite == ($past(wd, 3) == 8'h00)) else $error("nrd");
  AST_TAI: assert property (wa == 9'h1f1 && wd == 8'h00 |-> ##3 time_a_illegal) else $error("time_a");
  AST_DHT: assert property (wa == 9'h1f2 && wd == 8'h00 |-> ##3 !params.detection_hold_enable) else $error("hold");
  AST_CFO: assert property (wa == 9'h1f3 |-> ##3 params.calibration_offset_one == $past(wd, 3)) else $error("cfo");
  AST_IDL: assert property (wa == 9'h1f5 && wd == 8'h00 |-> ##3 params.idle_time_zero == 9'h100) else $error("idle");
  AST_PRD: assert property (|key_pos_recal |-> (key_pos_recal & ~$past(key_above_positive_threshold)) == '0) else $error("recal");
  cover property (crc_error);
  cover property (|key_pos_recal);
  cover property (time_a_illegal);
endmodule
bind tsdc_setup_check tsdc_sca #(.KEYS(KEYS)) u_sca (.core_clk(core_clk), .rstn(rstn), .setup_wr(setup_wr),
  .setup_raddr(setup_raddr), .setup_rdata(setup_rdata), .thr_index(thr_index), .thr_counts(thr_counts),
  .key_above_positive_threshold(key_above_positive_threshold), .key_pos_recal(key_pos_recal), .crc_error(crc_error),
  .time_a_illegal(time_a_illegal), .computed_crc(computed_crc), .params(params));

// ===== tb/tsdc_host.sv
`timescale 1ns/100ps
`include "tsdc_map.svh"
// ==========
// Host that uploads the setups image and seals it.
module tsdc_host (
  input wire logic core_clk,
  output tsdc_pkg::tsdc_wr_t wr
);
  logic [7:0] img [0:248];
  logic [15:0] sum;
  initial wr = '0;
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr <= '{1'b1, a, d};
    @(posedge core_clk);
    wr <= '{1'b0, ~a, ~d};
    @(posedge core_clk);
  endtask
  task automatic upload(input logic bad);
    sum = `TSDC_CRC_INIT;
    for (int i = 0; i < 249; i++) begin
      sum ^= {img[i], 8'h00};
      repeat (8) sum = sum[15] ? {sum[14:0], 1'b0} ^ `TSDC_CRC_POLY : {sum[14:0], 1'b0};
    end
    sum ^= {15'h0, bad};
    for (int i = 0; i < 249; i++) put(i[7:0], img[i]);
    put(`TSDC_CRC_LO_ADDR, sum[7:0]);
    put(`TSDC_CRC_HI_ADDR, sum[15:8]);
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "tsdc_map.svh"
// ==========
// Bench.
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] setup_raddr = 8'h00;
  logic [3:0] thr_index = 4'h0;
  logic [23:0] key_above_positive_threshold = 24'h0;
  logic [23:0] pat;
  logic [7:0] setup_rdata;
  logic [5:0] thr_counts;
  logic [23:0] key_pos_recal;
  logic crc_error;
  logic time_a_illegal;
  logic [15:0] computed_crc;
  tsdc_pkg::tsdc_wr_t wr;
  tsdc_pkg::tsdc_params_t p;
  int mismatches = 0;
  int comparisons = 0;
  int n = 0;
  tsdc_host host (.core_clk(core_clk), .wr(wr));
  tsdc_setup_check #(.PRD_CYCLES(20)) DUT (.core_clk(core_clk), .rstn(rstn), .setup_wr(wr), .setup_raddr(setup_raddr),
    .setup_rdata(setup_rdata), .thr_index(thr_index), .thr_counts(thr_counts), .key_above_positive_threshold(key_above_positive_threshold),
    .key_pos_recal(key_pos_recal), .crc_error(crc_error), .time_a_illegal(time_a_illegal),
    .computed_crc(computed_crc), .params(p));
  initial forever #4 core_clk = ~core_clk;
  function automatic logic [8:0] idle(input logic [7:0] v);
    return v == 8'h00 ? 9'h100 : {1'b0, v};
  endfunction
  task chk(input string s, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(75579));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 249; i++) host.img[i] = $urandom;
    for (int k = 0; k < 3; k++) begin
      for (int a = 240; a < 248; a++) host.img[a] = k == 0 ? 8'h00 : k == 1 ? 8'hff : $urandom;
      if (k == 2) host.img[241][0] = 1'b1;
      host.upload(k == 2);
      repeat (510) @(posedge core_clk);
      #1;
      chk("crc_error", k == 2, crc_error);
      chk("computed_crc", host.sum ^ 16'(k == 2), computed_crc);
      chk("nrd", host.img[240] * `TSDC_NRD_STEP_CYCLES, p.neg_recal_cycles);
      chk("nrd_inf", host.img[240] == 8'h00, p.neg_recal_infinite);
      chk("time_a", host.img[241] * `TSDC_TENTH_STEP_CYCLES, p.time_a_cycles);
      chk("illegal", host.img[241] == 8'h00, time_a_illegal);
      chk("hold", host.img[242] * `TSDC_TENTH_STEP_CYCLES, p.detection_hold_cycles);
      chk("hold_en", host.img[242] != 8'h00, p.detection_hold_enable);
      chk("cfo", {host.img[244], host.img[243]}, {p.calibration_offset_two, p.calibration_offset_one});
      chk("idle", {idle(host.img[245]), idle(host.img[246]), idle(host.img[247])}, {p.idle_time_zero, p.idle_time_one,
        p.idle_time_two});
      for (int a = 249; a < 252; a++) begin
        @(posedge core_clk);
        setup_raddr <= a[7:0];
        repeat (2) @(posedge core_clk);
        #1;
        chk("rdata", {8'h00, host.sum} >> 8 * (a - 249) & 24'hff, setup_rdata);
      end
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      thr_index <= i[3:0];
      repeat (2) @(posedge core_clk);
      #1;
      chk("thr", i < 8 ? 4 + 2 * i : 18, thr_counts);
    end
    pat = $urandom | 24'h1;
    @(posedge core_clk);
    key_above_positive_threshold <= pat;
    while (key_pos_recal === 24'h0 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("recal_keys", pat, key_pos_recal);
    chk("recal_time", 1, n >= 19 && n <= 22);
    wrap_up();
  end
endmodule
